// ==== core/ppmcd_power_csr.sv ====
// power management control/status, data byte and second-function config map
//
// Behaviour
// R1: wake event sets status bit 15 always
// R2: writing one clears wake status; zero keeps
// R3: clear also releases pme and driver status
// R4: enabled pme follows wake status bit
// R5: cardbus one-write clears general wake flag
// R6: scale reads 10b for 0-8, else 00b
// R7: select bits 12:9 pick data, reset zero
// R8: bit 8 enable gates pme, reset zero
// R9: bit 4 dynamic data reads zero
// R10: reserved bits 7:5, 3:2 read zero
// R11: bits 1:0 power state, read/write
// R12: data byte is read-only, select dependent
// R13: data values fixed, 0.01 w units
// R14: select 0-3 give 60,42,42,42
// R15: select 4-7 give 60,42,42,42
// R16: select 8 gives 00; 9-15 zero
// R17: lan is function 0, modem function 1
// R18: modem hidden per serial memory setting
// R19: modem subsystem id and int line mirror lan counterparts
// R20: sources: constants, serial memory, software
// R21: capability at dch, csr+data at e0h
// R22: modem csr behaves like lan csr
// R23: capability id reads 01h
// R24: reserved modem offsets read zero
`timescale 1ns/10ps
`default_nettype none
`include "ppmcd_defs.svh"

module ppmcd_power_csr (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               cfg_req,
  input  wire logic               cfg_write,
  input  wire ppmcd_pkg::ppmcd_func_t cfg_func,
  input  wire logic [7:0]         cfg_offset,
  input  wire logic [3:0]         cfg_byte_en,
  input  wire logic [31:0]        cfg_wdata,
  output logic                    cfg_ack,
  output logic                    cfg_retry,
  output logic                    cfg_unclaimed,
  output logic [31:0]             cfg_rdata,
  input  wire logic [1:0]         wake_event,
  input  wire logic               cardbus_mode,
  input  wire logic               aux_power,
  input  wire logic [7:0]         lan_int_line,
  input  wire logic               ee_load,
  input  wire logic               ee_modem_en,
  input  wire logic [31:0]        ee_modem_ident,
  input  wire logic [7:0]         ee_modem_rev,
  input  wire logic [31:0]        ee_subsys,
  output logic                    pme_out,
  output logic                    pme_oe,
  output logic [1:0]              driver_wake_status,
  output logic [1:0]              general_wake_flag,
  output logic [1:0]              power_state_lan,
  output logic [1:0]              power_state_modem,
  output logic                    modem_visible
);
  import ppmcd_pkg::*;

  // ========================================
  // decode helpers
  function automatic logic [7:0] data_byte(input ppmcd_sel_t sel);
    unique case (sel)
      4'h0, 4'h4: data_byte = `PPMCD_DATA_D0;                    // R14 R15
      4'h1, 4'h2, 4'h3,
      4'h5, 4'h6, 4'h7: data_byte = `PPMCD_DATA_DX;              // R14 R15
      4'h8: data_byte = `PPMCD_DATA_COMMON;                      // R16
      default: data_byte = 8'h00;                                // R16
    endcase
  endfunction : data_byte

  function automatic logic [1:0] data_scale(input ppmcd_sel_t sel);
    data_scale = (sel <= `PPMCD_SEL_LAST_KNOWN) ? `PPMCD_SCALE_KNOWN
                                                : `PPMCD_SCALE_NONE; // R6
  endfunction : data_scale

  // ========================================
  // state
  logic [1:0]         wake_status_q;
  logic [1:0]         wake_en_q;
  ppmcd_sel_t         sel_q [2];
  logic [1:0]         pstate_q [2];
  logic               loaded_q;
  logic               modem_en_q;
  logic [31:0]        modem_ident_q;
  logic [7:0]         modem_rev_q;
  logic [31:0]        subsys_q;
  logic [15:0]        cmd_q;
  logic [31:0]        io_base_q;
  logic [31:0]        mem_base_q;
  logic [31:0]        rom_base_q;
  logic [1:0]         drv_status_q;
  logic [1:0]         general_wake_flag_q;
  logic               ack_q;
  logic               retry_q;
  logic               unclaimed_q;
  logic [31:0]        rdata_q;
  logic               pme_oe_q;
  logic               pme_out_q;

  logic               access;
  logic               wr;
  logic [15:0]        csr_word [2];
  logic [31:0]        rd_word;
  logic               hit;
  logic [1:0]         csr_wr;
  logic [1:0]         clr_wake;

  // before the serial memory load, accesses are retried; hidden modem is unclaimed
  assign access = cfg_req && loaded_q && (cfg_func == PPMCD_FUNC_LAN || modem_en_q); // R17 R18
  assign wr     = access && cfg_write;

  // ========================================
  // per-function power csr
  genvar f;
  generate
    for (f = 0; f < 2; f++) begin : g_fn
      assign csr_wr[f]   = wr && cfg_func == ppmcd_func_t'(f)
                           && cfg_offset == `PPMCD_OFF_PM_CSR;   // R21 R22
      assign clr_wake[f] = csr_wr[f] && cfg_byte_en[1]
                           && cfg_wdata[`PPMCD_BIT_WAKE_STATUS]; // R2
      always_comb begin
        csr_word[f] = 16'h0000;                                  // R9 R10
        csr_word[f][`PPMCD_BIT_WAKE_STATUS] = wake_status_q[f];
        csr_word[f][`PPMCD_SCALE_HI:`PPMCD_SCALE_LO] = data_scale(sel_q[f]); // R6
        csr_word[f][`PPMCD_SEL_HI:`PPMCD_SEL_LO] = sel_q[f];
        csr_word[f][`PPMCD_BIT_WAKE_EN] = wake_en_q[f];
        csr_word[f][`PPMCD_PSTATE_HI:`PPMCD_PSTATE_LO] = pstate_q[f];
      end

      // set beats clear so an event in the clearing cycle survives
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          wake_status_q[f] <= 1'b0;
        end else if (wake_event[f]) begin
          wake_status_q[f] <= 1'b1;                              // R1
        end else if (clr_wake[f]) begin
          wake_status_q[f] <= 1'b0;                              // R2
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          drv_status_q[f] <= 1'b0;
        end else if (wake_event[f]) begin
          drv_status_q[f] <= 1'b1;
        end else if (clr_wake[f]) begin
          drv_status_q[f] <= 1'b0;                               // R3
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          general_wake_flag_q[f] <= 1'b0;
        end else if (wake_event[f] && cardbus_mode) begin
          general_wake_flag_q[f] <= 1'b1;
        end else if (clr_wake[f] && cardbus_mode) begin
          general_wake_flag_q[f] <= 1'b0;                                    // R5
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          wake_en_q[f] <= 1'b0;                                  // R8
          sel_q[f]     <= `PPMCD_SEL_RESET;                      // R7
        end else if (csr_wr[f] && cfg_byte_en[1]) begin
          wake_en_q[f] <= cfg_wdata[`PPMCD_BIT_WAKE_EN];
          sel_q[f]     <= cfg_wdata[`PPMCD_SEL_HI:`PPMCD_SEL_LO]; // R7
        end
      end

      // any encoding is stored; the requested state is reported back as is
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          pstate_q[f] <= `PPMCD_PSTATE_RESET;
        end else if (csr_wr[f] && cfg_byte_en[0]) begin
          pstate_q[f] <= cfg_wdata[`PPMCD_PSTATE_HI:`PPMCD_PSTATE_LO]; // R11
        end
      end
    end
  endgenerate

  // ========================================
  // pme pin, open drain, one shared pin for both functions
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pme_oe_q  <= 1'b0;
      pme_out_q <= 1'b0;
    end else begin
      pme_oe_q  <= |(wake_status_q & wake_en_q);                 // R4 R8 R3
      pme_out_q <= 1'b0;
    end
  end

  // ========================================
  // serial memory load
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loaded_q      <= 1'b0;
      modem_en_q    <= 1'b0;
      modem_ident_q <= 32'h0000_0000;
      modem_rev_q   <= 8'h00;
      subsys_q      <= 32'h0000_0000;
    end else if (ee_load) begin
      loaded_q      <= 1'b1;
      modem_en_q    <= ee_modem_en;                              // R18
      modem_ident_q <= ee_modem_ident;                           // R20
      modem_rev_q   <= ee_modem_rev;                             // R20
      subsys_q      <= ee_subsys;                                // R19 R20
    end
  end

  // ========================================
  // modem software registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
    logic [31:0] m;
    m = wmask & {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                 {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
    merge = (old & ~m) | (cfg_wdata & m);
  endfunction : merge

  logic mwr;
  assign mwr = wr && cfg_func == PPMCD_FUNC_MODEM;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q      <= 16'h0000;
      io_base_q  <= 32'h0000_0000;
      mem_base_q <= 32'h0000_0000;
      rom_base_q <= 32'h0000_0000;
    end else if (mwr) begin
      unique case (cfg_offset)
        `PPMCD_OFF_CMD_STAT: cmd_q      <= 16'(merge({16'h0000, cmd_q},
                                                     {16'h0000, `PPMCD_CMD_WMASK})); // R20
        `PPMCD_OFF_IO_BASE:  io_base_q  <= merge(io_base_q, `PPMCD_IO_WMASK);
        `PPMCD_OFF_MEM_BASE: mem_base_q <= merge(mem_base_q, `PPMCD_MEM_WMASK);
        `PPMCD_OFF_ROM_BASE: rom_base_q <= merge(rom_base_q, `PPMCD_ROM_WMASK);
        default: ;                                               // R24
      endcase
    end
  end

  // ========================================
  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    hit     = 1'b1;
    if (cfg_func == PPMCD_FUNC_LAN) begin                        // R17
      unique case (cfg_offset)
        `PPMCD_OFF_PM_CAP: rd_word = {(aux_power ? `PPMCD_PMC_AUX_LAN : `PPMCD_PMC_NOAUX),
                                      `PPMCD_CAP_NEXT, `PPMCD_CAP_ID}; // R23
        `PPMCD_OFF_PM_CSR: rd_word = {8'h00, data_byte(sel_q[0]), csr_word[0]}; // R12 R13
        default: hit = 1'b0;
      endcase
    end else begin
      unique case (cfg_offset)
        `PPMCD_OFF_IDENT:    rd_word = modem_ident_q;
        `PPMCD_OFF_CMD_STAT: rd_word = {`PPMCD_STATUS_FIXED, cmd_q};
        `PPMCD_OFF_REV_CLASS: rd_word = {`PPMCD_CLASS_CODE, modem_rev_q};
        `PPMCD_OFF_HDR_MISC: rd_word = `PPMCD_HDR_VAL;
        `PPMCD_OFF_IO_BASE:  rd_word = io_base_q | `PPMCD_IO_SPACE_BIT;
        `PPMCD_OFF_MEM_BASE: rd_word = mem_base_q;
        `PPMCD_OFF_CIS_PTR:  rd_word = cardbus_mode ? `PPMCD_CIS_VAL : 32'h0000_0000;
        `PPMCD_OFF_SUBSYS:   rd_word = subsys_q;                 // R19
        `PPMCD_OFF_ROM_BASE: rd_word = rom_base_q;
        `PPMCD_OFF_CAP_PTR:  rd_word = {24'h000000, `PPMCD_CAP_PTR_VAL}; // R21
        `PPMCD_OFF_INT_LAT:  rd_word = {`PPMCD_MAX_LAT, `PPMCD_MIN_GNT,
                                        `PPMCD_INT_PIN, lan_int_line}; // R19
        `PPMCD_OFF_PM_CAP:   rd_word = {(aux_power ? `PPMCD_PMC_AUX_MODEM : `PPMCD_PMC_NOAUX),
                                        `PPMCD_CAP_NEXT, `PPMCD_CAP_ID}; // R21 R23
        `PPMCD_OFF_PM_CSR:   rd_word = {8'h00, data_byte(sel_q[1]), csr_word[1]}; // R21 R22
        default:             rd_word = 32'h0000_0000;            // R24
      endcase
    end
  end

  // ========================================
  // answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_q       <= 1'b0;
      retry_q     <= 1'b0;
      unclaimed_q <= 1'b0;
      rdata_q     <= 32'h0000_0000;
    end else begin
      ack_q       <= access && hit;
      retry_q     <= cfg_req && !loaded_q;
      unclaimed_q <= cfg_req && loaded_q && !(access && hit); // R18
      rdata_q     <= (access && hit && !cfg_write) ? rd_word : 32'h0000_0000;
    end
  end

  assign cfg_ack            = ack_q;
  assign cfg_retry          = retry_q;
  assign cfg_unclaimed      = unclaimed_q;
  assign cfg_rdata          = rdata_q;
  assign pme_oe             = pme_oe_q;
  assign pme_out            = pme_out_q;
  assign driver_wake_status = drv_status_q;
  assign general_wake_flag  = general_wake_flag_q;
  assign power_state_lan    = pstate_q[0];
  assign power_state_modem  = pstate_q[1];
  assign modem_visible      = modem_en_q;

  // ========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_wake_sets: assert property (wake_event[0] |=> wake_status_q[0]) // R1
    else $error("wake event did not set status");
  a_wake_clears: assert property (clr_wake[1] && !wake_event[1] |=> !wake_status_q[1]) // R2
    else $error("one-write did not clear status");
  a_zero_keeps: assert property (csr_wr[0] && cfg_byte_en[1] && !cfg_wdata[15] // R2
                                 && wake_status_q[0] |=> wake_status_q[0])
    else $error("zero-write changed status");
  a_pme_follow: assert property (##1 pme_oe == $past(|(wake_status_q & wake_en_q))) // R4
    else $error("pme does not follow enabled status");
  a_pme_gated: assert property (wake_en_q == 2'b00 |=> !pme_oe) // R8
    else $error("pme asserted while disabled");
  a_drv_clear: assert property (clr_wake[0] && !wake_event[0] |=> !driver_wake_status[0]) // R3
    else $error("driver status not cleared");
  a_general_wake_flag_clear: assert property (clr_wake[0] && cardbus_mode && !wake_event[0] // R5
                                  |=> !general_wake_flag[0])
    else $error("general wake flag not cleared");
  a_scale_sel: assert property (csr_word[0][14:13] == ((sel_q[0] <= 4'h8) ? 2'b10 : 2'b00)) // R6
    else $error("scale field wrong");
  a_reserved_zero: assert property (csr_word[1][7:2] == 6'h00) // R9 R10
    else $error("reserved csr bits nonzero");
  a_read_lan_csr: assert property (access && !cfg_write && cfg_func == PPMCD_FUNC_LAN // R14
                                   && cfg_offset == 8'he0 && sel_q[0] == 4'h0
                                   |=> cfg_ack && cfg_rdata[23:16] == 8'h3c)
    else $error("d0 power data wrong");
  a_hidden_modem: assert property (cfg_req && loaded_q && !modem_en_q // R18
                                   && cfg_func == PPMCD_FUNC_MODEM
                                   |=> cfg_unclaimed && !cfg_ack)
    else $error("hidden modem answered");
  a_pstate_write: assert property (csr_wr[1] && cfg_byte_en[0] // R11
                                   |=> power_state_modem == $past(cfg_wdata[1:0]))
    else $error("power state not written");
  a_wake_mdm: assert property (wake_event[1] |=> wake_status_q[1]) // R1 R22
    else $error("modem wake event did not set status");
  // one answer per request keeps the host's single-cycle sampling unambiguous
  a_one_answer: assert property ($onehot0({cfg_ack, cfg_retry, cfg_unclaimed})) // R17
    else $error("more than one answer at once");
  a_ack_idle: assert property (!cfg_req |=> !cfg_ack) // R17
    else $error("answer without request");
  a_retry_early: assert property (cfg_req && !loaded_q // R18
                                  |=> cfg_retry && !cfg_ack && !cfg_unclaimed)
    else $error("early request not retried");
  a_data_none: assert property (access && !cfg_write && cfg_offset == 8'he0 // R6 R16
                                && (cfg_func == PPMCD_FUNC_LAN ? sel_q[0] : sel_q[1]) > 4'h8
                                |=> cfg_rdata[23:16] == 8'h00 && cfg_rdata[14:13] == 2'b00)
    else $error("reserved select reports data");
  a_mdm_reserved: assert property (access && !cfg_write && cfg_func == PPMCD_FUNC_MODEM // R24
                                   && cfg_offset == 8'h18 |=> cfg_ack && cfg_rdata == 32'h0)
    else $error("reserved modem offset not zero");
  a_cap_id: assert property (access && !cfg_write && cfg_offset == 8'hdc // R23
                             |=> cfg_rdata[7:0] == 8'h01)
    else $error("capability id wrong");

  c_wake_clear: cover property (wake_status_q[0] ##1 clr_wake[0] ##1 !wake_status_q[0]);
  c_pme_on: cover property (!pme_oe ##1 pme_oe);
  c_modem_read: cover property (access && cfg_func == PPMCD_FUNC_MODEM ##1 cfg_ack);
  c_retry: cover property (cfg_retry);
  c_mdm_clear: cover property (wake_status_q[1] ##1 clr_wake[1]);

endmodule : ppmcd_power_csr
`default_nettype wire

// ==== core/ppmcd_defs.svh ====
// offsets, field positions, reset values and fixed contents of the power csr block
`ifndef PPMCD_DEFS_SVH
`define PPMCD_DEFS_SVH
// ========================================
// configuration offsets (byte addresses)
`define PPMCD_OFF_IDENT        8'h00
`define PPMCD_OFF_CMD_STAT     8'h04
`define PPMCD_OFF_REV_CLASS    8'h08
`define PPMCD_OFF_HDR_MISC     8'h0c
`define PPMCD_OFF_IO_BASE      8'h10
`define PPMCD_OFF_MEM_BASE     8'h14
`define PPMCD_OFF_CIS_PTR      8'h28
`define PPMCD_OFF_SUBSYS       8'h2c
`define PPMCD_OFF_ROM_BASE     8'h30
`define PPMCD_OFF_CAP_PTR      8'h34
`define PPMCD_OFF_INT_LAT      8'h3c
`define PPMCD_OFF_PM_CAP       8'hdc
`define PPMCD_OFF_PM_CSR       8'he0
// ========================================
// power control/status word fields
`define PPMCD_BIT_WAKE_STATUS  15
`define PPMCD_SCALE_HI         14
`define PPMCD_SCALE_LO         13
`define PPMCD_SEL_HI           12
`define PPMCD_SEL_LO           9
`define PPMCD_BIT_WAKE_EN      8
`define PPMCD_PSTATE_HI        1
`define PPMCD_PSTATE_LO        0
`define PPMCD_SEL_RESET        4'h0
`define PPMCD_PSTATE_RESET     2'h0
`define PPMCD_SCALE_KNOWN      2'h2
`define PPMCD_SCALE_NONE       2'h0
`define PPMCD_SEL_LAST_KNOWN   4'h8
// ========================================
// power report data, units of 0.01 w
`define PPMCD_DATA_D0          8'h3c
`define PPMCD_DATA_DX          8'h2a
`define PPMCD_DATA_COMMON      8'h00
// ========================================
// fixed register contents
`define PPMCD_CAP_ID           8'h01
`define PPMCD_CAP_NEXT         8'h00
`define PPMCD_CAP_PTR_VAL      8'hdc
`define PPMCD_PMC_AUX_LAN      16'hfe21
`define PPMCD_PMC_AUX_MODEM    16'hfe31
`define PPMCD_PMC_NOAUX        16'h7e21
`define PPMCD_STATUS_FIXED     16'h0210
`define PPMCD_CLASS_CODE       24'h070002
`define PPMCD_HDR_VAL          32'h0080_0000
`define PPMCD_CIS_VAL          32'h0000_0102
`define PPMCD_MIN_GNT          8'h08
`define PPMCD_MAX_LAT          8'h18
`define PPMCD_INT_PIN          8'h01
`define PPMCD_CMD_WMASK        16'h0143
`define PPMCD_IO_WMASK         32'hffff_fff8
`define PPMCD_IO_SPACE_BIT     32'h0000_0001
`define PPMCD_MEM_WMASK        32'hffff_f000
`define PPMCD_ROM_WMASK        32'hffff_f801
`endif

// ==== core/ppmcd_pkg.sv ====
// types shared by the power csr block
package ppmcd_pkg;
  // ========================================
  // configuration function number
  typedef enum logic {
    PPMCD_FUNC_LAN,
    PPMCD_FUNC_MODEM
  } ppmcd_func_t;
  // power state encodings
  typedef enum logic [1:0] {
    PPMCD_D0,
    PPMCD_D1,
    PPMCD_D2,
    PPMCD_D3
  } ppmcd_pstate_t;
  typedef logic [3:0] ppmcd_sel_t;
endpackage : ppmcd_pkg

// ==== verif/ppmcd_host_model.sv ====
// host bridge model issuing configuration cycles
`timescale 1ns/10ps
`default_nettype none
module ppmcd_host_model (
  input  wire logic                   clk_sys,
  output var  logic                   cfg_req,
  output var  logic                   cfg_write,
  output var  ppmcd_pkg::ppmcd_func_t cfg_func,
  output var  logic [7:0]             cfg_offset,
  output var  logic [3:0]             cfg_byte_en,
  output var  logic [31:0]            cfg_wdata,
  input  wire logic                   cfg_ack,
  input  wire logic                   cfg_retry,
  input  wire logic                   cfg_unclaimed,
  input  wire logic [31:0]            cfg_rdata
);
  import ppmcd_pkg::*;
  // ========================================
  // idle bus
  initial begin
    cfg_req = 1'b0;
    cfg_write = 1'b0;
    cfg_func = PPMCD_FUNC_LAN;
    cfg_offset = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end
  // ========================================
  // one-cycle request, answer sampled one cycle later
  // released write, offset, byte-enable and data lines are inverted so stale values never pass for live ones
  task automatic access(input logic fn, input logic wr, input logic [7:0] off,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [2:0] rsp);
    @(posedge clk_sys);
    #1;
    cfg_req = 1'b1;
    cfg_write = wr;
    cfg_func = ppmcd_func_t'(fn);
    cfg_offset = off;
    cfg_byte_en = be;
    cfg_wdata = wd;
    @(posedge clk_sys);
    #1;
    cfg_req = 1'b0;
    cfg_write = ~wr;
    cfg_offset = ~off;
    cfg_byte_en = ~be;
    cfg_wdata = ~wd;
    rd = cfg_rdata;
    rsp = {cfg_unclaimed, cfg_retry, cfg_ack};
  endtask : access
endmodule : ppmcd_host_model
`default_nettype wire

// ==== verif/ppmcd_power_csr_tb.sv ====
// self-checking bench for the power csr block
`timescale 1ns/10ps
`default_nettype none
module ppmcd_power_csr_tb;
  import ppmcd_pkg::*;
  logic clk_sys, rst_n, cfg_req, cfg_write, cfg_ack, cfg_retry, cfg_unclaimed;
  ppmcd_func_t cfg_func;
  logic [7:0] cfg_offset, lan_int_line, ee_modem_rev;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, ee_modem_ident, ee_subsys, rd;
  logic [1:0] wake_event, driver_wake_status, general_wake_flag;
  logic [1:0] power_state_lan, power_state_modem;
  logic cardbus_mode, aux_power, ee_load, ee_modem_en, pme_out, pme_oe, modem_visible;
  logic [2:0] rsp;
  int error_cnt, tests_run, cyc;
  ppmcd_host_model host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_func(cfg_func), .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_retry(cfg_retry),
    .cfg_unclaimed(cfg_unclaimed), .cfg_rdata(cfg_rdata));
  ppmcd_power_csr DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_offset(cfg_offset),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_retry(cfg_retry), .cfg_unclaimed(cfg_unclaimed), .cfg_rdata(cfg_rdata),
    .wake_event(wake_event), .cardbus_mode(cardbus_mode), .aux_power(aux_power),
    .lan_int_line(lan_int_line), .ee_load(ee_load), .ee_modem_en(ee_modem_en),
    .ee_modem_ident(ee_modem_ident), .ee_modem_rev(ee_modem_rev), .ee_subsys(ee_subsys),
    .pme_out(pme_out), .pme_oe(pme_oe), .driver_wake_status(driver_wake_status),
    .general_wake_flag(general_wake_flag), .power_state_lan(power_state_lan),
    .power_state_modem(power_state_modem), .modem_visible(modem_visible));
  // ========================================
  // clock, timeout, helpers
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic rd32(logic fn, logic [7:0] off);
    host.access(fn, 1'b0, off, 4'h0, 32'h0, rd, rsp);
  endtask : rd32
  task automatic wr32(logic fn, logic [7:0] off, logic [3:0] be, logic [31:0] wd);
    host.access(fn, 1'b1, off, be, wd, rd, rsp);
  endtask : wr32
  // expected csr dword: data byte, status, scale, select, enable, state
  function automatic logic [31:0] exp_csr(logic [3:0] s, logic [1:0] p, logic en, logic ws);
    logic [7:0] d;
    d = (s == 4'h0 || s == 4'h4) ? 8'h3c : (s < 4'h8 && s != 4'h0) ? 8'h2a : 8'h00;
    return {8'h00, d, ws, (s <= 4'h8) ? 2'b10 : 2'b00, s, en, 6'h00, p};
  endfunction : exp_csr
  task automatic start(logic men);
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    rd32(1'b0, 8'he0);
    check("early resp", rsp, 3'b010);
    ee_modem_en = men;
    ee_load = 1'b1;
    tick(1);
    ee_load = 1'b0;
    check("visible", modem_visible, men);
  endtask : start
  // ========================================
  // scenarios
  task automatic t_select();
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 16; s++) begin
        wr32(f[0], 8'he0, 4'b0011, {19'h3, s[3:0], 9'h0fc});
        rd32(f[0], 8'he0);
        check("csr sel", rd, exp_csr(s[3:0], 2'b00, 1'b0, 1'b0));
      end
      wr32(f[0], 8'he0, 4'b0010, 32'h0);
    end
  endtask : t_select
  task automatic t_pstate();
    for (int f = 0; f < 2; f++) begin
      for (int p = 0; p < 4; p++) begin
        wr32(f[0], 8'he0, 4'b0001, {30'h0, p[1:0]});
        check("pstate port", f ? power_state_modem : power_state_lan, p);
        rd32(f[0], 8'he0);
        check("csr pstate", rd, exp_csr(4'h0, p[1:0], 1'b0, 1'b0));
      end
      wr32(f[0], 8'he0, 4'b0001, 32'h0);
    end
  endtask : t_pstate
  task automatic t_wake();
    cardbus_mode = 1'b1;
    wake_event = 2'b01;
    tick(1);
    wake_event = 2'b00;
    check("drv status", driver_wake_status, 2'b01);
    check("general_wake_flag", general_wake_flag, 2'b01);
    tick(1);
    check("pme off", {pme_oe, pme_out}, 2'b00);
    rd32(1'b0, 8'he0);
    check("csr wake", rd, exp_csr(4'h0, 2'b00, 1'b0, 1'b1));
    wr32(1'b0, 8'he0, 4'b0010, 32'h0000_0100);
    tick(1);
    check("pme on", pme_oe, 1'b1);
    rd32(1'b0, 8'he0);
    check("csr zero wr", rd, exp_csr(4'h0, 2'b00, 1'b1, 1'b1));
    wr32(1'b0, 8'he0, 4'b0010, 32'h0000_8100);
    check("drv clr", driver_wake_status, 2'b00);
    check("general_wake_flag clr", general_wake_flag, 2'b00);
    tick(1);
    check("pme rel", pme_oe, 1'b0);
    rd32(1'b0, 8'he0);
    check("csr clr", rd, exp_csr(4'h0, 2'b00, 1'b1, 1'b0));
    wr32(1'b0, 8'he0, 4'b0010, 32'h0);
    wake_event = 2'b10;
    tick(1);
    wake_event = 2'b00;
    check("mdm wake", {general_wake_flag, driver_wake_status}, 4'b1010);
    wr32(1'b1, 8'he0, 4'b0010, 32'h0000_8000);
    check("mdm clr", {general_wake_flag, driver_wake_status}, 4'b0000);
    cardbus_mode = 1'b0;
  endtask : t_wake
  task automatic t_map();
    rd32(1'b1, 8'hdc);
    check("mdm cap aux", rd, 32'hfe31_0001);
    rd32(1'b0, 8'hdc);
    check("lan cap aux", rd, 32'hfe21_0001);
    aux_power = 1'b0;
    rd32(1'b1, 8'hdc);
    check("mdm cap", rd, 32'h7e21_0001);
    rd32(1'b1, 8'h34);
    check("cap ptr", rd, 32'h0000_00dc);
    rd32(1'b1, 8'h3c);
    check("int mirror", rd, {24'h180801, lan_int_line});
    rd32(1'b1, 8'h2c);
    check("subsys", rd, ee_subsys);
    rd32(1'b1, 8'h00);
    check("ident", rd, ee_modem_ident);
    wr32(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    rd32(1'b1, 8'h04);
    check("mdm cmd", rd, 32'h0210_0143);
    wr32(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
    rd32(1'b1, 8'h10);
    check("mdm io", rd, 32'hffff_fff9);
    rd32(1'b1, 8'h08);
    check("mdm rev", rd, 32'h0700_0203);
    rd32(1'b1, 8'h28);
    check("cis pci", rd, 32'h0);
    wr32(1'b1, 8'h18, 4'hf, 32'hffff_ffff);
    rd32(1'b1, 8'h18);
    check("rsvd resp", rsp, 3'b001);
    check("rsvd data", rd, 32'h0);
    rd32(1'b0, 8'h34);
    check("lan other", rsp, 3'b100);
  endtask : t_map
  task automatic t_hidden();
    start(1'b0);
    rd32(1'b1, 8'he0);
    check("hidden", rsp, 3'b100);
    rd32(1'b0, 8'he0);
    check("lan ack", rsp, 3'b001);
  endtask : t_hidden
  // ========================================
  // main sequence
  initial begin
    {rst_n, wake_event, cardbus_mode, ee_load, ee_modem_en, cyc} = '0;
    {error_cnt, tests_run} = '0;
    aux_power = 1'b1;
    lan_int_line = 8'h5a;
    ee_modem_ident = 32'h1357_2468; // arbitrary identity value
    ee_modem_rev = 8'h03;
    ee_subsys = 32'h9abc_4321; // arbitrary identity value
    start(1'b1);
    rd32(1'b0, 8'he0);
    check("csr reset", rd, 32'h003c_4000);
    t_select();
    t_pstate();
    t_wake();
    t_map();
    t_hidden();
    close_out();
  end
endmodule : ppmcd_power_csr_tb
`default_nettype wire
